// ---- core/sor_pkg.sv ----
// shared constants, opcodes and carriers of the supply output command block
package sor_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int VAL_W = 24;
  localparam int ADR_W = 8;
  localparam int FW_W  = 12;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADR_W-1:0] ADR_CMD        = 8'h00;
  localparam logic [ADR_W-1:0] ADR_ARG        = 8'h04;
  localparam logic [ADR_W-1:0] ADR_REPLY      = 8'h08;
  localparam logic [ADR_W-1:0] ADR_STATE      = 8'h0c;
  localparam logic [ADR_W-1:0] ADR_IRQ_STAT   = 8'h10;
  localparam logic [ADR_W-1:0] ADR_IRQ_MASK   = 8'h14;
  localparam logic [ADR_W-1:0] ADR_ACC_STAT   = 8'h18;
  localparam logic [ADR_W-1:0] ADR_FAULT      = 8'h1c;
  localparam logic [ADR_W-1:0] ADR_FAULT_MASK = 8'h20;

  // ---------------------------------------------------------------
  // command word fields
  // ---------------------------------------------------------------
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_OP_W      = 4;
  localparam int CMD_QUERY_BIT = 4;
  localparam int CMD_MILLI_BIT = 5;
  localparam int CMD_ARG_BIT   = 6;

  typedef enum logic [CMD_OP_W-1:0] {
    OP_OUTPUT      = 4'h0,
    OP_OV_AUTOTRIM = 4'h1,
    OP_OV_LIMIT    = 4'h2,
    OP_HOST_CTL    = 4'h3,
    OP_FW_VER      = 4'h4,
    OP_REARM       = 4'h5,
    OP_V_SETPT     = 4'h6,
    OP_I_SETPT     = 4'h7,
    OP_CAL_STATE   = 4'h8
  } sor_op_t;

  localparam logic [VAL_W-1:0] ARG_ON  = 24'h000001;
  localparam logic [VAL_W-1:0] ARG_OFF = 24'h000000;

  // ---------------------------------------------------------------
  // status, event and reply layouts
  // ---------------------------------------------------------------
  localparam int ST_OUT_EN  = 0;
  localparam int ST_ISOLATE = 1;
  localparam int ST_REMOTE  = 2;
  localparam int ST_HOSTCTL = 3;
  localparam int ST_TRIPPED = 4;
  localparam int ST_CAL     = 5;
  localparam int ST_ERR     = 6;
  localparam int STATUS_W   = 7;

  localparam int EV_DONE  = 0;
  localparam int EV_REPLY = 1;
  localparam int EV_ERROR = 2;
  localparam int EV_TRIP  = 3;
  localparam int EV_W     = 4;

  localparam int REPLY_FW_SLAVE_LSB = 0;

  // ---------------------------------------------------------------
  // scaling and reset values
  // ---------------------------------------------------------------
  localparam int MV_PER_V = 1000;
  localparam int OV_PCT   = 110;
  localparam int PCT_DIV  = 100;

  localparam logic RST_OUT_EN  = 1'b1;
  localparam logic RST_HOSTCTL = 1'b1;
  localparam logic RST_REMOTE  = 1'b0;
  localparam logic RST_CAL     = 1'b0;

  typedef struct packed {
    sor_op_t op;
    logic    query;
    logic    milli;
    logic    hasArg;
  } sor_cmd_t;

  typedef struct packed {
    logic [VAL_W-1:0] vMv;
    logic [VAL_W-1:0] iMa;
    logic [VAL_W-1:0] ovMv;
  } sor_setpts_t;
endpackage

// ---- core/sor_sticky.sv ----
// sticky flag bank: set wins over write-one clear, masked level summary
`timescale 1ns/100ps
module sor_sticky #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] setVec,
  input  wire logic [W-1:0] clrVec,
  input  wire logic [W-1:0] maskVec,
  output logic      [W-1:0] stat,
  output logic              irq
);
  if (W < 1) begin : g_bad_w
    $error("sor_sticky needs W of at least 1");
  end

  // ---------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------
  // an event landing in the clear cycle survives
  always_ff @(posedge clk) begin
    if (rst) begin
      stat <= '0;
    end else if (ce) begin
      stat <= (stat & ~clrVec) | setVec;
    end
  end

  // registered summary, moves at the same edge as the flags
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(((stat & ~clrVec) | setVec) & maskVec);
    end
  end
endmodule

// ---- core/sor_remote_cmds.sv ----
// remote command interpreter for supply output, over-voltage limit and host control
//
// Contract
// - output on with argument 1 or ON, off with argument 0 or OFF
// - while output is off, commands are stored but applied only after output on; only the setpoints wait here, other commands act at once
// - output enable comes up on after reset
// - turning output off also raises the isolation signal
// - output query replies 1 when enabled, 0 when disabled
// - autotrim runs calibration; host must switch calibration state on first
// - over-voltage limit in volts or millivolts, range zero to 110% of maximum
// - limit out of range or below voltage setting: discard, error lamp, fault flag
// - limit query replies the programmed trip point as a voltage
// - host control off: stay local, ignore host commands
// - host control on: enter remote mode on any host command
// - host control query replies the host control setting
// - firmware query replies master and slave versions in separate fields
// - rearm restores operation at present settings after protection shutdown
// - while protection holds output off, setpoints are stored, applied after rearm
// - fault bit sets only on status rising with its mask bit 1
`timescale 1ns/100ps
module sor_remote_cmds
  import sor_pkg::*;
#(
  parameter int                  VMAX_MV       = 60000,
  parameter logic [sor_pkg::FW_W-1:0] FW_MASTER_VER = 12'h101,  // arbitrary
  parameter logic [sor_pkg::FW_W-1:0] FW_SLAVE_VER  = 12'h102   // arbitrary
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [sor_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        protTrip,
  output logic                             outEnable,
  output logic                             isolate,
  output logic                             errLed,
  output logic                             remoteMode,
  output logic                             ovTrimStart,
  output sor_pkg::sor_setpts_t             applied,
  output logic                             irq
);
  import sor_pkg::*;

  localparam int MV_W = VAL_W + 10;
  localparam logic [MV_W-1:0] OV_MAX_MV = MV_W'((VMAX_MV * OV_PCT) / PCT_DIV);

  if (VMAX_MV <= 0 || (VMAX_MV / PCT_DIV) * OV_PCT >= (1 << VAL_W)) begin : g_bad_vmax
    $error("VMAX_MV out of range for VAL_W");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic sor_cmd_t decodeCmd(input logic [31:0] w);
    sor_cmd_t c;
    c.op     = sor_op_t'(w[CMD_OP_LSB +: CMD_OP_W]);
    c.query  = w[CMD_QUERY_BIT];
    c.milli  = w[CMD_MILLI_BIT];
    c.hasArg = w[CMD_ARG_BIT];
    return c;
  endfunction

  function automatic logic [MV_W-1:0] toMilli(input logic [VAL_W-1:0] a, input logic milli);
    return milli ? MV_W'(a) : MV_W'(a) * MV_W'(MV_PER_V);
  endfunction

  function automatic logic [31:0] laneMask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic                wbReq;
  logic                wbWr;
  logic [31:0]         wrMask;
  logic [VAL_W-1:0]    arg_r;
  logic [31:0]         replyVal_r;
  logic [EV_W-1:0]     irqMask_r;
  logic [STATUS_W-1:0] faultMask_r;
  logic [STATUS_W-1:0] statusPrev_r;
  logic                hostCtl_r;
  logic                calState_r;
  logic                tripped_r;
  sor_setpts_t         pend_r;
  sor_cmd_t            cmd;
  logic                cmdFire;
  logic                cmdTaken;
  logic [MV_W-1:0]     argMv;
  logic                argIsOn;
  logic                argIsOff;
  logic                outSet, outClr, outQuery;
  logic                ovSetOk, ovBad, ovQuery;
  logic                hostOn, hostOff, hostQuery, fwQuery;
  logic                trimGo, calOn, calOff, rearmGo, vsetGo, isetGo, badCmd;
  logic                errEvent;
  logic                anyQuery;
  logic [VAL_W-1:0]    replyData;
  logic [STATUS_W-1:0] statusVec;
  logic [EV_W-1:0]     evSet;
  logic [EV_W-1:0]     irqStat;
  logic [STATUS_W-1:0] accStat;
  logic [STATUS_W-1:0] faultStat;
  logic [STATUS_W-1:0] faultRise;

  // ---------------------------------------------------------------
  // bus slave: answers every access one cycle after the request
  // ---------------------------------------------------------------
  assign wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr   = wbReq & wb_we_i;
  assign wrMask = laneMask(wb_sel_i);

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= wbReq;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arg_r       <= '0;
      irqMask_r   <= '0;
      faultMask_r <= '0;
    end else if (ce && wbWr) begin
      if (wb_adr_i == ADR_ARG) begin
        arg_r <= (arg_r & wrMask[VAL_W-1:0]) ^ arg_r | (wb_dat_i[VAL_W-1:0] & wrMask[VAL_W-1:0]);
      end
      if (wb_adr_i == ADR_IRQ_MASK) begin
        irqMask_r <= (irqMask_r & ~wrMask[EV_W-1:0]) | (wb_dat_i[EV_W-1:0] & wrMask[EV_W-1:0]);
      end
      if (wb_adr_i == ADR_FAULT_MASK) begin
        faultMask_r <= (faultMask_r & ~wrMask[STATUS_W-1:0]) | (wb_dat_i[STATUS_W-1:0] & wrMask[STATUS_W-1:0]);
      end
    end
  end

  // unmapped offsets read zero and ignore writes
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= '0;
    end else if (ce && wbReq) begin
      case (wb_adr_i)
        ADR_ARG:        wb_dat_o <= {{(32-VAL_W){1'b0}}, arg_r};
        ADR_REPLY:      wb_dat_o <= replyVal_r;
        ADR_STATE:      wb_dat_o <= {{(32-STATUS_W){1'b0}}, statusVec};
        ADR_IRQ_STAT:   wb_dat_o <= {{(32-EV_W){1'b0}}, irqStat};
        ADR_IRQ_MASK:   wb_dat_o <= {{(32-EV_W){1'b0}}, irqMask_r};
        ADR_ACC_STAT:   wb_dat_o <= {{(32-STATUS_W){1'b0}}, accStat};
        ADR_FAULT:      wb_dat_o <= {{(32-STATUS_W){1'b0}}, faultStat};
        ADR_FAULT_MASK: wb_dat_o <= {{(32-STATUS_W){1'b0}}, faultMask_r};
        default:        wb_dat_o <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  assign cmd      = decodeCmd(wb_dat_i);
  assign cmdFire  = wbWr && wb_adr_i == ADR_CMD && wb_sel_i[0];
  // local mode drops everything but the host control command itself
  assign cmdTaken = cmdFire && (hostCtl_r || cmd.op == OP_HOST_CTL);
  assign argMv    = toMilli(arg_r, cmd.milli);
  assign argIsOn  = cmd.hasArg && arg_r == ARG_ON;
  assign argIsOff = cmd.hasArg && arg_r == ARG_OFF;

  always_comb begin
    {outSet, outClr, outQuery, ovSetOk, ovBad, ovQuery} = '0;
    {hostOn, hostOff, hostQuery, fwQuery} = '0;
    {trimGo, calOn, calOff, rearmGo, vsetGo, isetGo, badCmd} = '0;
    if (cmdTaken) begin
      case (cmd.op)
        OP_OUTPUT: begin
          if (cmd.query) outQuery = 1'b1;
          else if (argIsOn) outSet = 1'b1;
          else if (argIsOff) outClr = 1'b1;
          else badCmd = 1'b1;
        end
        OP_OV_LIMIT: begin
          if (cmd.query) ovQuery = 1'b1;
          else if (!cmd.hasArg || argMv > OV_MAX_MV || argMv < MV_W'(pend_r.vMv)) ovBad = 1'b1;
          else ovSetOk = 1'b1;
        end
        OP_HOST_CTL: begin
          if (cmd.query) hostQuery = 1'b1;
          else if (argIsOn) hostOn = 1'b1;
          else if (argIsOff) hostOff = 1'b1;
          else badCmd = 1'b1;
        end
        OP_FW_VER: begin
          if (cmd.query) fwQuery = 1'b1;
          else badCmd = 1'b1;
        end
        OP_OV_AUTOTRIM: begin
          if (!cmd.query && calState_r) trimGo = 1'b1;
          else badCmd = 1'b1;
        end
        OP_CAL_STATE: begin
          if (!cmd.query && argIsOn) calOn = 1'b1;
          else if (!cmd.query && argIsOff) calOff = 1'b1;
          else badCmd = 1'b1;
        end
        OP_REARM: begin
          if (!cmd.query) rearmGo = 1'b1;
          else badCmd = 1'b1;
        end
        OP_V_SETPT, OP_I_SETPT: begin
          if (cmd.query || !cmd.hasArg || argMv[MV_W-1:VAL_W] != '0) badCmd = 1'b1;
          else if (cmd.op == OP_V_SETPT) vsetGo = 1'b1;
          else isetGo = 1'b1;
        end
        default: badCmd = 1'b1;
      endcase
    end
  end

  assign errEvent = badCmd | ovBad;
  assign anyQuery = outQuery | ovQuery | hostQuery | fwQuery;

  // ---------------------------------------------------------------
  // output enable and isolation
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      outEnable <= RST_OUT_EN;
      isolate   <= ~RST_OUT_EN;
    end else if (ce) begin
      if (outSet) begin
        outEnable <= 1'b1;
        isolate   <= 1'b0;
      end else if (outClr) begin
        outEnable <= 1'b0;
        isolate   <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // host control, remote mode, calibration state
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      hostCtl_r  <= RST_HOSTCTL;
      remoteMode <= RST_REMOTE;
    end else if (ce) begin
      if (hostOff) begin
        hostCtl_r  <= 1'b0;
        remoteMode <= 1'b0;
      end else begin
        if (hostOn) hostCtl_r <= 1'b1;
        if (cmdFire && hostCtl_r) remoteMode <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      calState_r  <= RST_CAL;
      ovTrimStart <= 1'b0;
    end else if (ce) begin
      if (calOn) calState_r <= 1'b1;
      else if (calOff) calState_r <= 1'b0;
      ovTrimStart <= trimGo;
    end
  end

  // ---------------------------------------------------------------
  // protection trip and error lamp; a new trip beats a rearm
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tripped_r <= 1'b0;
      errLed    <= 1'b0;
    end else if (ce) begin
      if (protTrip) tripped_r <= 1'b1;
      else if (rearmGo) tripped_r <= 1'b0;
      if (errEvent) errLed <= 1'b1;
      else if (rearmGo) errLed <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // setpoints: stored at once, applied only while output runs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r.vMv  <= '0;
      pend_r.iMa  <= '0;
      pend_r.ovMv <= OV_MAX_MV[VAL_W-1:0];
    end else if (ce) begin
      if (vsetGo) pend_r.vMv <= argMv[VAL_W-1:0];
      if (isetGo) pend_r.iMa <= argMv[VAL_W-1:0];
      if (ovSetOk) pend_r.ovMv <= argMv[VAL_W-1:0];
    end
  end

  // gating on both conditions covers output-off hold and trip hold alike
  always_ff @(posedge clk) begin
    if (rst) begin
      applied.vMv  <= '0;
      applied.iMa  <= '0;
      applied.ovMv <= OV_MAX_MV[VAL_W-1:0];
    end else if (ce && outEnable && !tripped_r) begin
      applied <= pend_r;
    end
  end

  // ---------------------------------------------------------------
  // reply register: op code above, value below
  // ---------------------------------------------------------------
  always_comb begin
    replyData = '0;
    if (outQuery) replyData = VAL_W'(outEnable);
    else if (ovQuery) replyData = pend_r.ovMv;
    else if (hostQuery) replyData = VAL_W'(hostCtl_r);
    else if (fwQuery) replyData = {FW_MASTER_VER, FW_SLAVE_VER};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      replyVal_r <= '0;
    end else if (ce && anyQuery) begin
      replyVal_r <= {{(32-CMD_OP_W-VAL_W){1'b0}}, cmd.op, replyData};
    end
  end

  // ---------------------------------------------------------------
  // interrupt, accumulated status and fault banks
  // ---------------------------------------------------------------
  always_comb begin
    statusVec             = '0;
    statusVec[ST_OUT_EN]  = outEnable;
    statusVec[ST_ISOLATE] = isolate;
    statusVec[ST_REMOTE]  = remoteMode;
    statusVec[ST_HOSTCTL] = hostCtl_r;
    statusVec[ST_TRIPPED] = tripped_r;
    statusVec[ST_CAL]     = calState_r;
    statusVec[ST_ERR]     = errLed;
  end

  always_comb begin
    evSet           = '0;
    evSet[EV_DONE]  = cmdTaken;
    evSet[EV_REPLY] = anyQuery;
    evSet[EV_ERROR] = errEvent;
    evSet[EV_TRIP]  = protTrip & ~tripped_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      statusPrev_r <= '0;
    end else if (ce) begin
      statusPrev_r <= statusVec;
    end
  end

  assign faultRise = statusVec & ~statusPrev_r & faultMask_r;

  sor_sticky #(.W(EV_W)) u_irq (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .setVec  (evSet),
    .clrVec  ((wbWr && wb_adr_i == ADR_IRQ_STAT) ? wb_dat_i[EV_W-1:0] & wrMask[EV_W-1:0] : '0),
    .maskVec (irqMask_r),
    .stat    (irqStat),
    .irq     (irq)
  );

  // error lamp sets its bit here through statusVec
  sor_sticky #(.W(STATUS_W)) u_acc (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .setVec  (statusVec),
    .clrVec  ((wbWr && wb_adr_i == ADR_ACC_STAT) ? wb_dat_i[STATUS_W-1:0] & wrMask[STATUS_W-1:0] : '0),
    .maskVec ('1),
    .stat    (accStat),
    .irq     ()
  );

  sor_sticky #(.W(STATUS_W)) u_fault (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .setVec  (faultRise),
    .clrVec  ((wbWr && wb_adr_i == ADR_FAULT) ? wb_dat_i[STATUS_W-1:0] & wrMask[STATUS_W-1:0] : '0),
    .maskVec ('1),
    .stat    (faultStat),
    .irq     ()
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_out_on: assert property (ce && outSet |=> outEnable && !isolate)
    else $error("output not enabled after on command");
  chk_power_up: assert property (@(posedge clk) disable iff (1'b0) rst |=> outEnable)
    else $error("output not enabled after reset");
  chk_isolate_off: assert property (ce && outClr |=> isolate ##0 !outEnable)
    else $error("isolation not raised on output off");
  chk_hold_off: assert property (!outEnable |=> $stable(applied))
    else $error("setpoint applied while output off");
  chk_trip_hold: assert property (tripped_r |=> $stable(applied))
    else $error("setpoint applied while tripped");
  chk_local_ignore: assert property (ce && cmdFire && !hostCtl_r && cmd.op != OP_HOST_CTL
    |=> $stable(outEnable) && !ovTrimStart)
    else $error("command acted on in local mode");
  chk_remote_enter: assert property (ce && cmdFire && hostCtl_r && !hostOff |=> remoteMode)
    else $error("remote mode not entered");
  chk_ov_reject: assert property (ce && ovBad |=> errLed && $stable(pend_r.ovMv) ##1 accStat[ST_ERR])
    else $error("bad limit not rejected");
  chk_out_query: assert property (ce && outQuery |=> replyVal_r[0] == $past(outEnable))
    else $error("output query reply wrong");
  chk_fw_labels: assert property (ce && fwQuery |=> replyVal_r[REPLY_FW_SLAVE_LSB +: FW_W] == FW_SLAVE_VER
    && replyVal_r[FW_W +: FW_W] == FW_MASTER_VER)
    else $error("firmware reply wrong");
  chk_rearm_clear: assert property (ce && rearmGo && !protTrip |=> !tripped_r && !errLed)
    else $error("rearm did not restore");
  chk_trim_gate: assert property (ovTrimStart |-> $past(calState_r))
    else $error("autotrim started without calibration state");
  chk_fault_edge: assert property (ce && faultRise == '0 && !(wbWr && wb_adr_i == ADR_FAULT)
    |=> $stable(faultStat))
    else $error("fault bit set without masked rise");
  chk_wb_ack: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

// ---- tb/sor_host_model.sv ----
// host-side wishbone master model for the supply command block
`timescale 1ns/100ps
module sor_host_model (
  input  wire logic                      clk,
  output logic                           cyc,
  output logic                           stb,
  output logic                           we,
  output logic [sor_pkg::ADR_W-1:0]      adr,
  output logic [3:0]                     sel,
  output logic [31:0]                    dat,
  input  wire logic [31:0]               datI,
  input  wire logic                      ack
);
  import sor_pkg::*;
  initial {cyc, stb, we, adr, sel, dat} = '0;
  // ----
  // bus cycles
  // ----
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {1'b1, 1'b1, w, a, 4'hf, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = datI;
    {cyc, stb, we} <= 3'b000;
  endtask
  // argument always lands before the keyword word
  task automatic cmd(input logic [6:0] w, input logic [23:0] a);
    logic [31:0] q;
    acc(1'b1, ADR_ARG, {8'h00, a}, q);
    acc(1'b1, ADR_CMD, {25'h0, w}, q);
  endtask
endmodule

// ---- tb/tb_supply_output_remote_cmds.sv ----
// self-checking bench of the supply output command block
`timescale 1ns/100ps
module tb_supply_output_remote_cmds;
  import sor_pkg::*;
  localparam logic [31:0] OVMAX = 60000 * OV_PCT / PCT_DIV;
  logic        clk = 0;
  logic        rst = 1;
  logic        protTrip = 0;
  logic        ce = 1;
  logic        cyc, stb, we, ack, outEnable, isolate, errLed, remoteMode, ovTrimStart, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW, datR, q;
  sor_setpts_t applied;
  int          n_fail = 0;
  int          tests_run = 0;
  int          trims = 0;
  always #10 clk = ~clk;
  always @(posedge clk) if (ovTrimStart === 1'b1) trims++;
  sor_host_model host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(datW), .datI(datR), .ack(ack));
  sor_remote_cmds #(.VMAX_MV(60000), .FW_MASTER_VER(12'h101), .FW_SLAVE_VER(12'h102)) DUT (
    .clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
    .protTrip(protTrip), .outEnable(outEnable), .isolate(isolate), .errLed(errLed),
    .remoteMode(remoteMode), .ovTrimStart(ovTrimStart), .applied(applied), .irq(irq));
  // ----
  // checks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic qry(input logic [6:0] w, input logic [31:0] e);
    host.cmd(w, 24'h0);
    host.acc(1'b0, ADR_REPLY, 32'h0, q);
    chk(q, {4'h0, w[3:0], e[23:0]});
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // span is far beyond the sequence length
  initial begin
    #200us;
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle();
    chb(outEnable, 1'b1);
    chk({8'h00, applied.ovMv}, OVMAX);
    // a trip seen only while the enable is low must leave no trace
    @(posedge clk);
    ce       <= 1'b0;
    protTrip <= 1'b1;
    @(posedge clk);
    protTrip <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    host.acc(1'b0, ADR_STATE, 32'h0, q);
    chb(q[ST_TRIPPED], 1'b0);
    qry(7'h10, 32'h1);
    qry(7'h13, 32'h1);
    chb(remoteMode, 1'b1);
    qry(7'h14, 32'h101102);
    host.acc(1'b1, ADR_FAULT_MASK, 32'h2, q);
    host.acc(1'b1, ADR_IRQ_MASK, 32'h1, q);
    host.acc(1'b1, ADR_IRQ_STAT, 32'hf, q);
    settle();
    chb(irq, 1'b0);
    host.cmd(7'h40, 24'h0);
    settle();
    chb(outEnable, 1'b0);
    chb(isolate, 1'b1);
    chb(irq, 1'b1);
    host.acc(1'b0, ADR_FAULT, 32'h0, q);
    chk(q, 32'h2);
    qry(7'h10, 32'h0);
    host.cmd(7'h66, 24'd5000);
    settle();
    chk({8'h00, applied.vMv}, 32'd0);
    host.cmd(7'h40, 24'h1);
    settle();
    chk({8'h00, applied.vMv}, 32'd5000);
    host.cmd(7'h62, OVMAX[23:0] + 24'd1);
    settle();
    chb(errLed, 1'b1);
    host.acc(1'b0, ADR_ACC_STAT, 32'h0, q);
    chb(q[ST_ERR], 1'b1);
    host.cmd(7'h62, 24'd4999);
    qry(7'h12, OVMAX);
    host.cmd(7'h62, 24'd30000);
    qry(7'h12, 32'd30000);
    host.cmd(7'h42, 24'd31);
    qry(7'h12, 32'd31000);
    host.cmd(7'h01, 24'h0);
    host.cmd(7'h48, 24'h1);
    host.cmd(7'h01, 24'h0);
    settle();
    chk(trims, 32'd1);
    @(posedge clk) protTrip <= 1'b1;
    @(posedge clk) protTrip <= 1'b0;
    host.cmd(7'h66, 24'd7000);
    host.cmd(7'h47, 24'd2);
    settle();
    chk({8'h00, applied.vMv}, 32'd5000);
    chk({8'h00, applied.iMa}, 32'd0);
    host.cmd(7'h05, 24'h0);
    settle();
    chk({8'h00, applied.vMv}, 32'd7000);
    chk({8'h00, applied.iMa}, 32'd2000);
    chb(errLed, 1'b0);
    host.cmd(7'h43, 24'h0);
    settle();
    chb(remoteMode, 1'b0);
    host.cmd(7'h40, 24'h0);
    settle();
    chb(outEnable, 1'b1);
    host.cmd(7'h43, 24'h1);
    settle();
    qry(7'h13, 32'h1);
    chb(remoteMode, 1'b1);
    host.acc(1'b0, 8'h30, 32'h0, q);
    chk(q, 32'h0);
    report_and_stop();
  end
endmodule
